// file: hw/pss_pkg.sv
// constants, field layouts and carrier types of the serial packet server
// assumes one 40 MHz clock and a packet parser that checks the checksum
//
// Functional notes
// R01 - system info: two 8-byte version strings, length 16
// R02 - port info: seven fields in order, length 17
// R03 - result byte first, zero means success
// R04 - current and voltage sent high byte first
// R05 - circular event queue, newest overwrites oldest
// R06 - all events in one reply, length three per event
// R07 - at most 85 events in one reply
// R08 - host polls with the event fetch routine
// R09 - bad checksum or unknown routine: no reply
// R10 - host retries or gives up after one second
// R11 - every 30 seconds save changed configuration
// R12 - link deaf and mute during flash backup
// R13 - event: type, signed first, unsigned second parameter
// R14 - port or supply number in second parameter
// R15 - signed system status codes, negative means error
// R16 - system status change raises an event
// R17 - port status codes zero to six
// R18 - returned events leave the queue
package pss_pkg;

    // ==========================================================
    // timing
    localparam int unsigned CLK_HZ             = 40_000_000;
    localparam int unsigned BACKUP_PERIOD_S    = 30;
    localparam int unsigned BACKUP_CYCLES      = CLK_HZ * BACKUP_PERIOD_S;
    localparam int unsigned FLASH_WRITE_CYCLES = 1000;

    // ==========================================================
    // routine codes and reply sizes
    localparam logic [7:0] routine_code_system_info = 8'h01;
    localparam logic [7:0] routine_code_port_info   = 8'h02;
    localparam logic [7:0] routine_code_event_fetch = 8'h03;
    localparam logic [7:0] LEN_SYSTEM_INFO          = 8'h10;
    localparam logic [7:0] LEN_PORT_INFO            = 8'h11;
    localparam logic [7:0] EVENT_BYTES              = 8'h03;
    localparam logic [7:0] MAX_EVENTS               = 8'h55;
    localparam int unsigned EVQ_DEPTH               = 85;
    localparam logic [7:0] VERSION_BYTES            = 8'h08;

    // ==========================================================
    // event types, system and port status codes
    localparam logic [7:0] EVT_SYSTEM       = 8'h01;
    localparam logic [7:0] EVT_PORT         = 8'h02;
    localparam logic [7:0] EVT_SUPPLY       = 8'h04;
    localparam logic [7:0] EVT_ERROR        = 8'h08;
    localparam logic [7:0] EVT_INFO         = 8'h10;
    localparam logic [7:0] SYS_OK           = 8'h00;
    localparam logic [7:0] SYS_INIT_FAIL    = 8'hff;
    localparam logic [7:0] system_state_undervoltage = 8'hfe;
    localparam logic [7:0] SYS_OVER_TEMP    = 8'hfd;
    localparam logic [7:0] system_state_link_lost    = 8'hfc;
    // R17 port status codes
    localparam logic [7:0] PORT_DISABLED    = 8'h00;
    localparam logic [7:0] PORT_POWERED_ON  = 8'h01;
    localparam logic [7:0] PORT_POWERED_OFF = 8'h02;
    localparam logic [7:0] PORT_DENIED      = 8'h03;
    localparam logic [7:0] PORT_BLOCKED     = 8'h04;
    localparam logic [7:0] PORT_FORCED_ON   = 8'h05;
    localparam logic [7:0] PORT_FORCED_OFF  = 8'h06;

    // ==========================================================
    // register map, byte addresses
    localparam logic [4:0] REG_CONFIG     = 5'h00;
    localparam logic [4:0] REG_SAVED      = 5'h04;
    localparam logic [4:0] REG_STATUS     = 5'h08;
    localparam logic [4:0] REG_IRQ_STATUS = 5'h0c;
    localparam logic [4:0] REG_IRQ_MASK   = 5'h10;
    localparam logic [31:0] CONFIG_RESET  = 32'h0000_0000;
    localparam int STS_BACKUP_BIT = 0;
    localparam int STS_TX_BIT     = 1;
    localparam int STS_COUNT_LSB  = 8;
    localparam int IRQ_EVENT_BIT  = 0;
    localparam int IRQ_LOST_BIT   = 1;
    localparam int IRQ_DROP_BIT   = 2;
    localparam int IRQ_SAVED_BIT  = 3;
    localparam int IRQ_BITS       = 4;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [7:0] kind;
        logic [7:0] event_param_first;
        logic [7:0] event_param_second;
    } pss_event_type;

    typedef struct packed {
        logic [7:0]  result;
        logic [7:0]  detection;
        logic [7:0]  classification;
        logic [15:0] current;
        logic [15:0] supply_voltage_field;
        logic [15:0] silicon_version;
        logic [63:0] firmware_version;
    } pss_port_info_type;

endpackage : pss_pkg

// file: hw/pss_event_queue.sv
// circular event store with overwrite of the oldest entry when full
// assumes a synchronously released reset and one pop per cycle at most
`timescale 1ns/1ps
module pss_event_queue #(
    parameter int unsigned DEPTH = pss_pkg::EVQ_DEPTH
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   push,
    input  pss_pkg::pss_event_type      push_data,
    input  wire logic                   pop,
    output pss_pkg::pss_event_type      head,
    output logic [7:0]                  count,
    output logic                        overwrote
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][23:0] mem;
        logic [AW-1:0]          rd;
        logic [7:0]             cnt;
    } pss_evq_state_type;

    pss_evq_state_type q;
    pss_evq_state_type n;

    function automatic logic [AW-1:0] wrap(input int unsigned v);
        wrap = (v >= DEPTH) ? AW'(v - DEPTH) : AW'(v);
    endfunction : wrap
    logic full;
    logic do_pop;

    assign full      = (q.cnt == 8'(DEPTH));
    assign do_pop    = pop && (q.cnt != 8'h00);
    assign head      = pss_pkg::pss_event_type'(q.mem[q.rd]);
    assign count     = q.cnt;
    // R05 oldest lost
    assign overwrote = push && full && !do_pop;

    always_comb
    begin
        n = q;
        if (push)
        begin
            // R05 circular store
            n.mem[wrap(int'(q.rd) + int'(q.cnt))] = push_data;
        end
        if (do_pop || overwrote)
        begin
            n.rd = wrap(int'(q.rd) + 1);
        end
        if (push && !full && !do_pop)
        begin
            n.cnt = q.cnt + 8'h01;
        end
        else if (!push && do_pop)
        begin
            n.cnt = q.cnt - 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= n;
        end
    end

endmodule : pss_event_queue

// file: hw/pss_server.sv
// serial packet server: answers parsed requests with formatted replies
// assumes a parser upstream that frames packets and checks the checksum;
// the reply stream is routine, length, then the data bytes
`timescale 1ns/1ps
module pss_server #(
    parameter int unsigned BACKUP_CYCLES  = pss_pkg::BACKUP_CYCLES,
    parameter int unsigned FLASH_CYCLES   = pss_pkg::FLASH_WRITE_CYCLES,
    parameter int unsigned EVQ_DEPTH      = pss_pkg::EVQ_DEPTH,
    parameter logic [63:0] MANAGER_VER    = 64'h7631_2e30_0000_0000,
    parameter logic [63:0] PLATFORM_VER   = 64'h7631_2e30_0000_0000
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic [4:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic [31:0]                 avs_readdata,
    output logic                        avs_waitrequest,
    output logic                        irq,
    input  wire logic                   rx_valid,
    output logic                        rx_ready,
    input  wire logic [7:0]             rx_routine,
    input  wire logic                   rx_checksum_ok,
    input  pss_pkg::pss_port_info_type  port_info,
    input  wire logic                   ev_valid,
    input  pss_pkg::pss_event_type      ev_data,
    input  wire logic [7:0]             sys_status,
    output logic                        tx_valid,
    input  wire logic                   tx_ready,
    output logic [7:0]                  tx_data,
    output logic                        tx_last,
    output logic                        backup_busy
);
    // ==========================================================
    // types and state
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SEND  = 3'b010,
        ST_FLASH = 3'b100
    } pss_state_type;

    typedef struct packed {
        pss_state_type              state;
        logic [7:0]                 routine;
        logic [7:0]                 length;
        logic [7:0]                 idx;
        logic [1:0]                 ev_sub;
        pss_pkg::pss_event_type     ev_hold;
        pss_pkg::pss_port_info_type pinfo;
        logic                       tx_valid;
        logic [7:0]                 tx_data;
        logic                       tx_last;
        logic [31:0]                tick_cnt;
        logic [31:0]                flash_cnt;
        logic                       backup_due;
        logic [31:0]                config_w;
        logic [31:0]                saved;
        logic [7:0]                 last_sys;
        logic [pss_pkg::IRQ_BITS-1:0] irq_sts;
        logic [pss_pkg::IRQ_BITS-1:0] irq_mask;
        logic                       rd_ack;
        logic [31:0]                rdata;
    } pss_main_state_type;

    pss_main_state_type q;
    pss_main_state_type n;

    // ==========================================================
    // reset release
    logic [1:0] rst_sync_q;
    logic       rst_int_n;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_sync_q <= 2'b00;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_int_n = rst_sync_q[1];

    // ==========================================================
    // event queue
    logic                   evq_push;
    pss_pkg::pss_event_type evq_in;
    logic                   evq_pop;
    pss_pkg::pss_event_type evq_head;
    logic [7:0]             evq_count;
    logic                   evq_lost;

    pss_event_queue #(
        .DEPTH      (EVQ_DEPTH)
    ) u_evq (
        .clk        (clk),
        .rst_n      (rst_int_n),
        .push       (evq_push),
        .push_data  (evq_in),
        .pop        (evq_pop),
        .head       (evq_head),
        .count      (evq_count),
        .overwrote  (evq_lost)
    );

    // R16 system status change
    always_comb
    begin
        evq_push = ev_valid || (sys_status != q.last_sys);
        evq_in   = ev_data;
        if (!ev_valid)
        begin
            // R13 system event layout
            evq_in.kind               = pss_pkg::EVT_SYSTEM;
            // R15 signed status code
            evq_in.event_param_first  = sys_status;
            evq_in.event_param_second = 8'h00;
        end
    end

    // ==========================================================
    // reply byte selection
    function automatic logic [7:0] str_byte(input logic [63:0] s,
                                            input logic [7:0]  k);
        str_byte = s[8'd63 - {k[2:0], 3'b000} -: 8];
    endfunction : str_byte

    // R02 port record order
    function automatic logic [7:0] port_byte(
        input pss_pkg::pss_port_info_type p,
        input logic [7:0]                 k);
        case (k)
            // R03 result leads
            8'd0:    port_byte = p.result;
            8'd1:    port_byte = p.detection;
            8'd2:    port_byte = p.classification;
            // R04 high byte first
            8'd3:    port_byte = p.current[15:8];
            8'd4:    port_byte = p.current[7:0];
            8'd5:    port_byte = p.supply_voltage_field[15:8];
            8'd6:    port_byte = p.supply_voltage_field[7:0];
            8'd7:    port_byte = p.silicon_version[15:8];
            8'd8:    port_byte = p.silicon_version[7:0];
            default: port_byte = str_byte(p.firmware_version, k - 8'd9);
        endcase
    endfunction : port_byte

    // ==========================================================
    // next state
    logic        bus_wr;
    logic [31:0] wmask;
    logic        routine_ok;
    logic        accept;
    logic [7:0]  nidx;
    logic [7:0]  dbyte;
    logic [7:0]  ev_take;
    logic        start_backup;
    logic [pss_pkg::IRQ_BITS-1:0] irq_set;
    logic [pss_pkg::IRQ_BITS-1:0] irq_clr;

    assign routine_ok = (rx_routine == pss_pkg::routine_code_system_info)
                     || (rx_routine == pss_pkg::routine_code_port_info)
                     || (rx_routine == pss_pkg::routine_code_event_fetch);
    // R11 only when changed
    assign start_backup = (q.state == ST_IDLE) && q.backup_due
                       && (q.config_w != q.saved);
    // R12 deaf while saving
    assign rx_ready = rst_int_n && (q.state == ST_IDLE) && !q.backup_due;
    assign accept   = q.tx_valid && tx_ready;
    assign nidx     = q.idx + 8'h01;
    assign bus_wr   = avs_write;
    assign wmask    = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    // R07 cap at 85
    assign ev_take  = (evq_count > pss_pkg::MAX_EVENTS) ?
                      pss_pkg::MAX_EVENTS : evq_count;

    always_comb
    begin
        n       = q;
        evq_pop = 1'b0;
        dbyte   = 8'h00;
        irq_set = '0;
        irq_clr = '0;
        irq_set[pss_pkg::IRQ_EVENT_BIT] = evq_push;
        irq_set[pss_pkg::IRQ_LOST_BIT]  = evq_lost;
        if (!ev_valid)
        begin
            n.last_sys = sys_status;
        end

        // R11 periodic check
        if (q.tick_cnt >= BACKUP_CYCLES - 1)
        begin
            n.tick_cnt   = 32'h0;
            n.backup_due = 1'b1;
        end
        else
        begin
            n.tick_cnt = q.tick_cnt + 32'h1;
        end

        case (q.state)
            ST_IDLE:
            begin
                if (start_backup)
                begin
                    n.state     = ST_FLASH;
                    n.flash_cnt = 32'h0;
                    n.saved     = q.config_w;
                end
                else if (q.backup_due)
                begin
                    n.backup_due = 1'b0;
                end
                else if (rx_valid)
                begin
                    // R09 silent drop
                    if (!rx_checksum_ok || !routine_ok)
                    begin
                        irq_set[pss_pkg::IRQ_DROP_BIT] = 1'b1;
                    end
                    else
                    begin
                        n.state    = ST_SEND;
                        n.routine  = rx_routine;
                        n.pinfo    = port_info;
                        n.idx      = 8'h00;
                        n.ev_sub   = 2'b00;
                        n.tx_valid = 1'b1;
                        n.tx_data  = rx_routine;
                        n.tx_last  = 1'b0;
                        if (rx_routine == pss_pkg::routine_code_system_info)
                        begin
                            // R01 length 16
                            n.length = pss_pkg::LEN_SYSTEM_INFO;
                        end
                        else if (rx_routine == pss_pkg::routine_code_port_info)
                        begin
                            // R02 length 17
                            n.length = pss_pkg::LEN_PORT_INFO;
                        end
                        else
                        begin
                            // R06 three bytes each
                            n.length = 8'(ev_take * pss_pkg::EVENT_BYTES);
                        end
                    end
                end
            end
            ST_SEND:
            begin
                if (accept)
                begin
                    if (q.tx_last)
                    begin
                        n.tx_valid = 1'b0;
                        n.tx_last  = 1'b0;
                        n.state    = ST_IDLE;
                    end
                    else
                    begin
                        n.idx     = nidx;
                        n.tx_last = (nidx == q.length + 8'h01);
                        if (nidx == 8'h01)
                        begin
                            dbyte = q.length;
                        end
                        else if (q.routine == pss_pkg::routine_code_system_info)
                        begin
                            // R01 manager then platform
                            if (nidx - 8'h02 < pss_pkg::VERSION_BYTES)
                            begin
                                dbyte = str_byte(MANAGER_VER, nidx - 8'h02);
                            end
                            else
                            begin
                                dbyte = str_byte(PLATFORM_VER, nidx - 8'h0a);
                            end
                        end
                        else if (q.routine == pss_pkg::routine_code_port_info)
                        begin
                            dbyte = port_byte(q.pinfo, nidx - 8'h02);
                        end
                        else
                        begin
                            case (q.ev_sub)
                                2'b00:
                                begin
                                    // R18 drain as sent
                                    evq_pop   = 1'b1;
                                    n.ev_hold = evq_head;
                                    dbyte     = evq_head.kind;
                                    n.ev_sub  = 2'b01;
                                end
                                2'b01:
                                begin
                                    dbyte    = q.ev_hold.event_param_first;
                                    n.ev_sub = 2'b10;
                                end
                                default:
                                begin
                                    // R14 port or supply number
                                    dbyte    = q.ev_hold.event_param_second;
                                    n.ev_sub = 2'b00;
                                end
                            endcase
                        end
                        n.tx_data = dbyte;
                    end
                end
            end
            ST_FLASH:
            begin
                // R12 link held off
                if (q.flash_cnt >= FLASH_CYCLES - 1)
                begin
                    n.state      = ST_IDLE;
                    n.backup_due = 1'b0;
                    irq_set[pss_pkg::IRQ_SAVED_BIT] = 1'b1;
                end
                else
                begin
                    n.flash_cnt = q.flash_cnt + 32'h1;
                end
            end
            default:
            begin
                n.state = ST_IDLE;
            end
        endcase

        // ======================================================
        // register writes, set beats clear on the status bits
        if (bus_wr)
        begin
            case (avs_address)
                pss_pkg::REG_CONFIG:
                begin
                    n.config_w = (q.config_w & ~wmask)
                               | (avs_writedata & wmask);
                end
                pss_pkg::REG_IRQ_STATUS:
                begin
                    irq_clr = avs_writedata[pss_pkg::IRQ_BITS-1:0]
                            & wmask[pss_pkg::IRQ_BITS-1:0];
                end
                pss_pkg::REG_IRQ_MASK:
                begin
                    n.irq_mask = (q.irq_mask & ~wmask[pss_pkg::IRQ_BITS-1:0])
                               | (avs_writedata[pss_pkg::IRQ_BITS-1:0]
                                  & wmask[pss_pkg::IRQ_BITS-1:0]);
                end
                default:
                begin
                end
            endcase
        end
        n.irq_sts = (q.irq_sts & ~irq_clr) | irq_set;

        // one wait state on reads, data from a flop
        n.rd_ack = avs_read && !q.rd_ack;
        if (avs_read && !q.rd_ack)
        begin
            case (avs_address)
                pss_pkg::REG_CONFIG:     n.rdata = q.config_w;
                pss_pkg::REG_SAVED:      n.rdata = q.saved;
                pss_pkg::REG_STATUS:
                begin
                    n.rdata = 32'h0;
                    n.rdata[pss_pkg::STS_BACKUP_BIT] = (q.state == ST_FLASH);
                    n.rdata[pss_pkg::STS_TX_BIT]     = (q.state == ST_SEND);
                    n.rdata[pss_pkg::STS_COUNT_LSB +: 8] = evq_count;
                end
                pss_pkg::REG_IRQ_STATUS: n.rdata = 32'(q.irq_sts);
                pss_pkg::REG_IRQ_MASK:   n.rdata = 32'(q.irq_mask);
                default:                 n.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_int_n)
    begin
        if (!rst_int_n)
        begin
            q          <= '0;
            q.state    <= ST_IDLE;
            q.config_w <= pss_pkg::CONFIG_RESET;
            q.saved    <= pss_pkg::CONFIG_RESET;
        end
        else
        begin
            q <= n;
        end
    end

    // ==========================================================
    // outputs
    assign avs_readdata    = q.rdata;
    assign avs_waitrequest = avs_read && !q.rd_ack;
    assign irq             = |(q.irq_sts & q.irq_mask);
    assign tx_valid        = q.tx_valid;
    assign tx_data         = q.tx_data;
    assign tx_last         = q.tx_last;
    assign backup_busy     = (q.state == ST_FLASH);

endmodule : pss_server

// file: testbench/pss_host.sv
// host side of the reply stream: takes every beat
// slow mode stalls each other cycle, as a busy host would
`timescale 1ns/1ps
module pss_host (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic slow,
    output logic      tx_ready
);
    logic ph_q;
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) ph_q <= 1'b0;
        else ph_q <= ~ph_q;
    assign tx_ready = !slow || ph_q;
endmodule : pss_host

// file: testbench/pss_monitor.sv
// port checker of the packet server
// bound to pss_server after endmodule, sees its ports only
`timescale 1ns/1ps
module pss_monitor (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       rx_valid,
    input wire logic       rx_ready,
    input wire logic [7:0] rx_routine,
    input wire logic       rx_checksum_ok,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic       tx_last,
    input wire logic       backup_busy
);
    // ========
    // first beat marker
    logic hd_q;
    wire  tk = rx_valid && rx_ready;
    wire  ac = tx_valid && tx_ready;
    wire  f1 = hd_q && ac;
    wire  ok = rx_checksum_ok && rx_routine inside {[8'h01:8'h03]};
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) hd_q <= 1'b0;
        else hd_q <= tk || (hd_q && !ac);
    reply_start_a: assert property (
        tk && ok |=> tx_valid && tx_data == $past(rx_routine)) else $error("no reply");
    drop_silent_a: assert property (
        tk && !ok |=> !tx_valid [*2]) else $error("reply to bad packet");
    sys_len_a: assert property (
        f1 && tx_data == 8'h01 |=> tx_data == 8'h10) else $error("sysinfo length");
    port_len_a: assert property (
        f1 && tx_data == 8'h02 |=> tx_data == 8'h11) else $error("portinfo length");
    ev_len_a: assert property (
        f1 && tx_data == 8'h03 |=> tx_data % 3 == 0) else $error("event length");
    beat_hold_a: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("beat lost");
    last_end_a: assert property (
        ac && tx_last |=> !tx_valid) else $error("reply overrun");
    flash_deaf_a: assert property (
        backup_busy |-> !rx_ready && !tx_valid) else $error("link active in flash");
    cover property (tk && rx_routine == 8'h03);
    cover property (backup_busy);
    cover property (ac && tx_last);
endmodule : pss_monitor
bind pss_server pss_monitor pss_monitor_inst (.clk, .rst_n, .rx_valid,
    .rx_ready, .rx_routine, .rx_checksum_ok, .tx_valid, .tx_ready, .tx_data,
    .tx_last, .backup_busy);

// file: testbench/pss_server_bench.sv
// self-checking bench of the packet server
// host modelled by pss_host, registers reached by the bus task
`timescale 1ns/1ps
module pss_server_bench;
    localparam logic [127:0] VER = 128'h6d31_0000_0000_0000_7032_2e31_0000_0000;
    localparam logic [135:0] PI = 136'h00_04_02_1234_beef_4131_3031323334353637;
    logic clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, rx_valid = 0;
    logic rx_checksum_ok = 0, ev_valid = 0, slow = 0;
    logic [4:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, rdat;
    logic [7:0] rx_routine = '0, sys_status = '0, tx_data;
    logic avs_waitrequest, irq, rx_ready, tx_valid, tx_ready, tx_last;
    logic backup_busy;
    pss_pkg::pss_event_type ev_data = '0;
    pss_pkg::pss_port_info_type port_info = PI;
    int bad_count = 0, checked = 0, cyc = 0;
    logic [7:0] q[$], e[$];
    pss_server #(.BACKUP_CYCLES(200), .FLASH_CYCLES(20), .EVQ_DEPTH(4),
        .MANAGER_VER(VER[127:64]), .PLATFORM_VER(VER[63:0])) pss_server_inst (
        .clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .irq,
        .rx_valid, .rx_ready, .rx_routine, .rx_checksum_ok, .port_info,
        .ev_valid, .ev_data, .sys_status, .tx_valid, .tx_ready, .tx_data,
        .tx_last, .backup_busy);
    pss_host pss_host_inst (.clk, .rst_n, .slow, .tx_ready);
    initial forever #12.5 clk = ~clk;
    always @(negedge clk) if (tx_valid && tx_ready) q.push_back(tx_data);
    task automatic test_done();
        if (bad_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    always @(posedge clk) if (++cyc > 6000) begin bad_count++; test_done(); end
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        checked++;
        if (s !== x)
        begin
            $display("BAD %0t %h %h", $time, s, x);
            bad_count++;
        end
    endtask : chk
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest);
        rdat = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic req(input logic [7:0] r, input logic c, input logic any);
        q = {};
        rx_routine <= r;
        rx_checksum_ok <= c;
        rx_valid <= 1'b1;
        do @(posedge clk); while (!rx_ready);
        rx_valid <= 1'b0;
        // a silent device gets a bounded wait
        if (!any) repeat (40) @(posedge clk);
        else do @(posedge clk); while (!(tx_valid && tx_ready && tx_last));
    endtask : req
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        bus(0, 5'h14, 0);
        chk(rdat, 0);
        req(8'h01, 0, 0);
        chk(q.size(), 0);
        req(8'h7e, 1, 0);
        chk(q.size(), 0);
        chk(irq, 0);
        bus(1, 5'h10, 32'h4);
        bus(0, 5'h0c, 0);
        chk({irq, rdat[30:0]}, 32'h8000_0004);
        bus(1, 5'h0c, 32'h4);
        bus(0, 5'h0c, 0);
        chk({irq, rdat[2]}, 0);
        for (int i = 0; i < 4; i++)
        begin
            ev_data <= {8'h02 << i, 8'hf1 + 8'(i), 8'h07 + 8'(i)};
            ev_valid <= 1'b1;
            @(posedge clk);
            ev_valid <= 1'b0;
            @(posedge clk);
        end
        sys_status <= 8'hfe;
        repeat (3) @(posedge clk);
        bus(0, 5'h0c, 0);
        chk(rdat, 32'h3);
        req(8'h03, 1, 1);
        chk(q[1], 12);
        e = {8'h04, 8'hf2, 8'h08, 8'h08, 8'hf3, 8'h09, 8'h10, 8'hf4, 8'h0a,
            8'h01, 8'hfe, 8'h00};
        for (int i = 0; i < 12; i++) chk(q[2+i], e[i]);
        req(8'h03, 1, 1);
        chk(q.size(), 2);
        slow <= 1'b1;
        req(8'h01, 1, 1);
        for (int i = 0; i < 16; i++) chk(q[2+i], VER[127-8*i -: 8]);
        req(8'h02, 1, 1);
        chk(q.size(), 19);
        for (int i = 0; i < 17; i++) chk(q[2+i], PI[135-8*i -: 8]);
        bus(1, 5'h00, 32'h5a);
        while (!backup_busy) @(posedge clk);
        req(8'h01, 1, 1);
        bus(0, 5'h04, 0);
        chk(rdat, 32'h5a);
        test_done();
    end
endmodule : pss_server_bench
